// *** logic/lvio_map.svh ***
// Overview of operation
// - First port direction set per nibble
// - One bit picks first port driver type
// - Hardware reset makes first port input
// - Output lines lose their pull-up
// - Second port direction set per line
// - One driver type for second port outputs
// - Power-on reset makes second port input
// - Second port OR and AND wake gates
// - Edge detector fed by third-port or second-port line
// - Third port: three inputs, four outputs, fixed
// - Mode bit makes two inputs analog
// - Two comparators against reference pins
// - Selectable edge for two input interrupts
// - Timer results routed to third-port outputs
// - Digital third input feeds bit three, request one
// - Comparators off in stop; digital recovery only
`ifndef LVIO_MAP_SVH
`define LVIO_MAP_SVH

`define LVIO_P0_DATA_RST 8'h00
`define LVIO_P2_DATA_RST 8'h00
`define LVIO_P2_DIR_RST 8'hFF
`define LVIO_P3_DATA_RST 4'h0
`define LVIO_P0_LO_BIT 0
`define LVIO_P0_HI_BIT 1
`define LVIO_PORT_CONFIGURATION_REGISTER_OD_BIT 2
`define LVIO_P3M_ANALOG_BIT 1
`define LVIO_IRQ_EDGE_LO_BIT 6
`define LVIO_IRQ_EDGE_HI_BIT 7
`define LVIO_P3_IN_DIGITAL_BIT 3

`endif

// *** logic/lvio_pkg.sv ***
package lvio_pkg;

   // Interrupt edge choice, from request register bits 7:6
   typedef enum logic [1:0] {
      LVIO_EDGE_FALL = 2'b00,
      LVIO_EDGE_RISE = 2'b01,
      LVIO_EDGE_BOTH = 2'b10,
      LVIO_EDGE_BOTH_ALT = 2'b11
   } lvio_edge_e;

   // Timer output routing, common timer control bits 5:4
   typedef enum logic [1:0] {
      LVIO_TOUT_NONE = 2'b00,
      LVIO_TOUT_NARROW = 2'b01,
      LVIO_TOUT_LOGIC = 2'b10,
      LVIO_TOUT_BOTH = 2'b11
   } lvio_tout_e;

endpackage

// *** logic/lvio_ports.sv ***
`timescale 1ns/1ns
`include "lvio_map.svh"

module lvio_ports
   import lvio_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // First port pins
   input wire logic [7:0] p0_pin_i,
   output logic [7:0] p0_pin_o,
   output logic [7:0] p0_pin_oe_o,
   output logic [7:0] p0_pullup_en_o,
   // First port software access
   input wire logic p0_mode_wr_i,
   input wire logic [1:0] p0_mode_i,
   input wire logic p0_wr_i,
   input wire logic [7:0] p0_wdata_i,
   output logic [7:0] p0_rdata_o,
   // Port configuration register
   input wire logic port_configuration_register_wr_i,
   input wire logic [7:0] port_configuration_register_i,
   // Second port pins
   input wire logic [7:0] p2_pin_i,
   output logic [7:0] p2_pin_o,
   output logic [7:0] p2_pin_oe_o,
   output logic [7:0] p2_pullup_en_o,
   // Second port software access
   input wire logic p2_dir_wr_i,
   input wire logic [7:0] p2_dir_i,
   input wire logic p2_od_i,
   input wire logic p2_wr_i,
   input wire logic [7:0] p2_wdata_i,
   output logic [7:0] p2_rdata_o,
   // Second port wake gates
   output logic p2_wake_or_o,
   output logic p2_wake_and_o,
   // Third port input pins and comparator front end
   input wire logic third_port_input_one_i,
   input wire logic third_port_input_two_i,
   input wire logic third_port_input_three_i,
   input wire logic cmp_one_result_i,
   input wire logic cmp_two_result_i,
   output logic cmp_power_en_o,
   // Third port output pins
   output logic third_port_output_four_o,
   output logic third_port_output_five_o,
   output logic third_port_output_six_o,
   output logic third_port_output_seven_o,
   // Third port software access
   input wire logic p3_mode_wr_i,
   input wire logic [7:0] p3_mode_i,
   input wire logic p3_wr_i,
   input wire logic [3:0] p3_wdata_i,
   output logic [3:0] p3_rdata_o,
   // Interrupt request register edge bits and requests
   input wire logic irq_cfg_wr_i,
   input wire logic [7:0] irq_cfg_i,
   output logic irq_req_zero_o,
   output logic interrupt_request_one_o,
   output logic irq_req_two_o,
   // Timer links
   input wire logic edge_src_sel_i,
   output logic timer_edge_in_o,
   input wire logic timer_common_control_wr_i,
   input wire logic [7:0] timer_common_control_i,
   input wire logic wide_timer_control_wr_i,
   input wire logic [7:0] wide_timer_control_i,
   input wire logic narrow_counter_timer_out_i,
   input wire logic wide_counter_timer_out_i,
   input wire logic and_or_logic_out_i,
   // Stop mode
   input wire logic stop_mode_i,
   output logic [2:0] stop_recovery_src_o
);

   function automatic logic edge_hit(input logic prev, input logic cur,
                                     input lvio_edge_e mode);
      logic rise;
      logic fall;
      rise = ~prev & cur;
      fall = prev & ~cur;
      case (mode)
         LVIO_EDGE_FALL: edge_hit = fall;
         LVIO_EDGE_RISE: edge_hit = rise;
         default: edge_hit = rise | fall;
      endcase
   endfunction

   function automatic logic [7:0] pin_drive_en(input logic [7:0] out_mode,
                                               input logic [7:0] data,
                                               input logic open_drain);
      // Open drain only ever pulls low
      pin_drive_en = out_mode & (open_drain ? ~data : 8'hFF);
   endfunction

   // Configuration registers
   logic [1:0] p0_nib_out_r;
   logic p0_od_r;
   logic cmp_out_en_r;
   logic [7:0] p0_data_r;
   logic [7:0] p2_out_r;
   logic [7:0] p2_data_r;
   logic p2_od_r;
   logic analog_r;
   logic [3:0] p3_data_r;
   lvio_edge_e edge_mode_r;
   lvio_tout_e tout_sel_r;
   logic wide_out_en_r;

   // Input synchronisers, first and second stage
   logic [7:0] p0_s1_r;
   logic [7:0] p0_s2_r;
   logic [7:0] p2_s1_r;
   logic [7:0] p2_s2_r;
   logic [2:0] p3_s1_r;
   logic [2:0] p3_s2_r;
   logic [1:0] cmp_s1_r;
   logic [1:0] cmp_s2_r;
   logic [2:0] p3_prev_r;

   // Output registers
   logic [7:0] p0_rdata_r;
   logic [7:0] p2_rdata_r;
   logic [3:0] p3_rdata_r;
   logic [3:0] p3_out_r;
   logic [2:0] irq_r;
   logic wake_or_r;
   logic wake_and_r;
   logic edge_in_r;

   logic [7:0] p0_out_mode;
   logic [2:0] p3_level;
   logic [2:0] p3_level_nxt;
   logic p34_nxt;
   logic p35_nxt;
   logic p36_nxt;
   logic p37_nxt;
   logic [2:0] irq_nxt;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p0_nib_out_r <= 2'b00;
         p0_od_r <= 1'b0;
         cmp_out_en_r <= 1'b0;
         p0_data_r <= `LVIO_P0_DATA_RST;
      end else begin
         if (p0_mode_wr_i) begin
            p0_nib_out_r <= p0_mode_i;
         end
         if (port_configuration_register_wr_i) begin
            p0_od_r <= ~port_configuration_register_i[`LVIO_PORT_CONFIGURATION_REGISTER_OD_BIT];
            cmp_out_en_r <= port_configuration_register_i[0];
         end
         if (p0_wr_i) begin
            p0_data_r <= p0_wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p2_out_r <= ~`LVIO_P2_DIR_RST;
         p2_data_r <= `LVIO_P2_DATA_RST;
         p2_od_r <= 1'b0;
      end else begin
         if (p2_dir_wr_i) begin
            p2_out_r <= ~p2_dir_i;
            p2_od_r <= p2_od_i;
         end
         if (p2_wr_i) begin
            p2_data_r <= p2_wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         analog_r <= 1'b0;
         p3_data_r <= `LVIO_P3_DATA_RST;
         edge_mode_r <= LVIO_EDGE_FALL;
         tout_sel_r <= LVIO_TOUT_NONE;
         wide_out_en_r <= 1'b0;
      end else begin
         if (p3_mode_wr_i) begin
            analog_r <= p3_mode_i[`LVIO_P3M_ANALOG_BIT];
         end
         if (p3_wr_i) begin
            p3_data_r <= p3_wdata_i;
         end
         if (irq_cfg_wr_i) begin
            edge_mode_r <= lvio_edge_e'(irq_cfg_i[`LVIO_IRQ_EDGE_HI_BIT:
                                         `LVIO_IRQ_EDGE_LO_BIT]);
         end
         if (timer_common_control_wr_i) begin
            tout_sel_r <= lvio_tout_e'(timer_common_control_i[5:4]);
         end
         if (wide_timer_control_wr_i) begin
            wide_out_en_r <= wide_timer_control_i[0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p0_s1_r <= 8'h00;
         p0_s2_r <= 8'h00;
         p2_s1_r <= 8'h00;
         p2_s2_r <= 8'h00;
         p3_s1_r <= 3'h0;
         p3_s2_r <= 3'h0;
         cmp_s1_r <= 2'h0;
         cmp_s2_r <= 2'h0;
      end else begin
         p0_s1_r <= p0_pin_i;
         p0_s2_r <= p0_s1_r;
         p2_s1_r <= p2_pin_i;
         p2_s2_r <= p2_s1_r;
         p3_s1_r <= {third_port_input_three_i, third_port_input_two_i,
                     third_port_input_one_i};
         p3_s2_r <= p3_s1_r;
         cmp_s1_r <= {cmp_two_result_i, cmp_one_result_i};
         cmp_s2_r <= cmp_s1_r;
      end
   end

   // Direction and driver selection
   assign p0_out_mode = {{4{p0_nib_out_r[`LVIO_P0_HI_BIT]}},
                         {4{p0_nib_out_r[`LVIO_P0_LO_BIT]}}};
   assign p0_pin_o = p0_data_r;
   assign p0_pin_oe_o = pin_drive_en(p0_out_mode, p0_data_r,
                                     p0_od_r);
   assign p0_pullup_en_o = ~p0_out_mode;
   assign p2_pin_o = p2_data_r;
   assign p2_pin_oe_o = pin_drive_en(p2_out_r, p2_data_r,
                                     p2_od_r);
   assign p2_pullup_en_o = ~p2_out_r;

   // Comparators sleep in stop, so analog lines cannot wake the part
   assign cmp_power_en_o = analog_r & ~stop_mode_i;
   assign stop_recovery_src_o = analog_r ? 3'h0 : p3_s2_r;

   // Analog mode swaps the two low input levels for comparator results
   assign p3_level_nxt = analog_r ? {1'b0, cmp_s2_r}
                                  : p3_s2_r;
   assign p3_level = p3_level_nxt;

   always_comb begin
      irq_nxt[2] = edge_hit(p3_prev_r[0], p3_level[0],
                            edge_mode_r);
      irq_nxt[0] = edge_hit(p3_prev_r[1], p3_level[1],
                            edge_mode_r);
      irq_nxt[1] = ~analog_r &
                   edge_hit(p3_prev_r[2], p3_level[2],
                            LVIO_EDGE_FALL);
   end

   // Fixed outputs; latch bits pass unless a timer or a comparator claims the pin
   always_comb begin
      p34_nxt = p3_data_r[0];
      p35_nxt = p3_data_r[1];
      p36_nxt = p3_data_r[2];
      p37_nxt = p3_data_r[3];
      if (tout_sel_r == LVIO_TOUT_NARROW || tout_sel_r == LVIO_TOUT_BOTH) begin
         p34_nxt = narrow_counter_timer_out_i;
      end
      if (tout_sel_r == LVIO_TOUT_LOGIC || tout_sel_r == LVIO_TOUT_BOTH) begin
         p36_nxt = and_or_logic_out_i;
      end
      if (wide_out_en_r) begin
         p35_nxt = wide_counter_timer_out_i;
      end
      if (cmp_out_en_r && analog_r) begin
         p34_nxt = cmp_s2_r[0];
         p37_nxt = cmp_s2_r[1];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p0_rdata_r <= 8'h00;
         p2_rdata_r <= 8'h00;
         p3_rdata_r <= 4'h0;
         p3_out_r <= `LVIO_P3_DATA_RST;
         p3_prev_r <= 3'h0;
         irq_r <= 3'h0;
         wake_or_r <= 1'b0;
         wake_and_r <= 1'b0;
         edge_in_r <= 1'b0;
      end else begin
         p0_rdata_r <= (p0_out_mode & p0_data_r) |
                       (~p0_out_mode & p0_s2_r);
         p2_rdata_r <= (p2_out_r & p2_data_r) |
                       (~p2_out_r & p2_s2_r);
         p3_rdata_r <= {p3_level[2] & ~analog_r,
                        p3_level[1:0], 1'b0};
         p3_out_r <= {p37_nxt, p36_nxt, p35_nxt, p34_nxt};
         p3_prev_r <= p3_level;
         irq_r <= irq_nxt;
         wake_or_r <= |p2_s2_r;
         wake_and_r <= &p2_s2_r;
         edge_in_r <= edge_src_sel_i ? p2_s2_r[0]
                                     : p3_s2_r[0];
      end
   end

   assign p0_rdata_o = p0_rdata_r;
   assign p2_rdata_o = p2_rdata_r;
   assign p3_rdata_o = p3_rdata_r;
   assign third_port_output_four_o = p3_out_r[0];
   assign third_port_output_five_o = p3_out_r[1];
   assign third_port_output_six_o = p3_out_r[2];
   assign third_port_output_seven_o = p3_out_r[3];
   assign irq_req_zero_o = irq_r[0];
   assign interrupt_request_one_o = irq_r[1];
   assign irq_req_two_o = irq_r[2];
   assign p2_wake_or_o = wake_or_r;
   assign p2_wake_and_o = wake_and_r;
   assign timer_edge_in_o = edge_in_r;

endmodule

// *** verification/lvio_ports_monitor.sv ***
`timescale 1ns/1ns
module lvio_ports_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // First port
   input wire logic [7:0] p0_pin_oe_o,
   input wire logic [7:0] p0_pullup_en_o,
   input wire logic p0_mode_wr_i,
   input wire logic [1:0] p0_mode_i,
   // Second port
   input wire logic [7:0] p2_pin_i,
   input wire logic [7:0] p2_pin_oe_o,
   input wire logic [7:0] p2_pullup_en_o,
   input wire logic p2_dir_wr_i,
   input wire logic [7:0] p2_dir_i,
   input wire logic p2_od_i,
   input wire logic p2_wake_or_o,
   input wire logic p2_wake_and_o,
   // Third port and timer links
   input wire logic third_port_input_one_i,
   input wire logic edge_src_sel_i,
   input wire logic timer_edge_in_o,
   input wire logic stop_mode_i,
   input wire logic cmp_power_en_o,
   input wire logic interrupt_request_one_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [1:0] up_r;
   // Pipeline checks wait until the synchronisers hold post-reset samples
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         up_r <= 2'h0;
      end else if (up_r != 2'h3) begin
         up_r <= up_r + 2'h1;
      end
   end
   pullup_off_a: assert property (
      (p0_pin_oe_o & p0_pullup_en_o) == 8'h00 &&
      (p2_pin_oe_o & p2_pullup_en_o) == 8'h00) else $error("pull-up on");
   reset_input_a: assert property ($rose(rst_n_i) |->
      p0_pin_oe_o == 8'h00 && p0_pullup_en_o == 8'hFF) else $error("p0 out");
   nibble_mode_a: assert property (p0_mode_wr_i |=>
      p0_pullup_en_o == {{4{!$past(p0_mode_i[1])}}, {4{!$past(p0_mode_i[0])}}})
      else $error("p0 nibble mode");
   line_dir_a: assert property (p2_dir_wr_i |=>
      p2_pullup_en_o == $past(p2_dir_i)) else $error("p2 direction");
   push_pull_a: assert property (p2_dir_wr_i && !p2_od_i |=>
      p2_pin_oe_o == ~$past(p2_dir_i)) else $error("p2 push-pull");
   wake_gate_a: assert property (up_r == 2'h3 |->
      p2_wake_or_o == |$past(p2_pin_i, 3) &&
      p2_wake_and_o == &$past(p2_pin_i, 3)) else $error("wake gates");
   edge_source_a: assert property (
      up_r == 2'h3 && $past(edge_src_sel_i) == $past(edge_src_sel_i, 3) |->
      timer_edge_in_o == ($past(edge_src_sel_i) ? $past(p2_pin_i[0], 3) :
      $past(third_port_input_one_i, 3))) else $error("edge source");
   stop_power_a: assert property (stop_mode_i |->
      !cmp_power_en_o) else $error("comparator powered in stop");
   irq_pulse_a: assert property (interrupt_request_one_o |=>
      !interrupt_request_one_o) else $error("request one too long");
   cover property (p2_dir_wr_i && !p2_od_i);
   cover property (interrupt_request_one_o);
   cover property (p2_wake_and_o);
endmodule
bind lvio_ports lvio_ports_monitor u_mon (.*);

// *** verification/lvio_board.sv ***
`timescale 1ns/1ns
module lvio_board (
   // Clock
   input wire logic clk_i,
   // Device side of one port
   input wire logic [7:0] oe_i,
   input wire logic [7:0] drv_i,
   input wire logic [7:0] pullup_i,
   // Board drivers
   input wire logic [7:0] ext_en_i,
   input wire logic [7:0] ext_val_i,
   // Resolved line levels
   output logic [7:0] level_o
);
   logic [7:0] float_r = 8'h55;
   // An undriven line without pull-up must never look stable
   always @(posedge clk_i) begin
      float_r <= ~float_r;
   end
   assign level_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_val_i) |
      (~oe_i & ~ext_en_i & (pullup_i | float_r));
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ns
module testbench;
   logic clk_i = '0, rst_n_i = '0, p0_mode_wr_i = '0, p0_wr_i = '0;
   logic port_configuration_register_wr_i = '0, p2_dir_wr_i = '0, p2_od_i = '0, p2_wr_i = '0;
   logic cmp_one_result_i = '0, cmp_two_result_i = '0, p3_mode_wr_i = '0;
   logic p3_wr_i = '0, irq_cfg_wr_i = '0, edge_src_sel_i = '0;
   logic timer_common_control_wr_i = '0, wide_timer_control_wr_i = '0;
   logic narrow_counter_timer_out_i = '0, wide_counter_timer_out_i = '0;
   logic and_or_logic_out_i = '0, stop_mode_i = '0;
   logic [1:0] p0_mode_i = '0;
   logic [2:0] tin = '0;
   logic [3:0] p3_wdata_i = '0;
   logic [7:0] p0_wdata_i = '0, port_configuration_register_i = '0, p2_dir_i = '0, p2_wdata_i = '0;
   logic [7:0] p3_mode_i = '0, irq_cfg_i = '0, timer_common_control_i = '0;
   logic [7:0] wide_timer_control_i = '0, e0 = '0, v0 = '0, e2 = '0, v2 = '0;
   logic [7:0] p0_pin_i, p0_pin_o, p0_pin_oe_o, p0_pullup_en_o, p0_rdata_o;
   logic [7:0] p2_pin_i, p2_pin_o, p2_pin_oe_o, p2_pullup_en_o, p2_rdata_o;
   logic [3:0] p3_rdata_o, p3o;
   logic [2:0] stop_recovery_src_o;
   logic p2_wake_or_o, p2_wake_and_o, cmp_power_en_o, timer_edge_in_o;
   logic third_port_output_four_o, third_port_output_five_o;
   logic third_port_output_six_o, third_port_output_seven_o;
   logic irq_req_zero_o, interrupt_request_one_o, irq_req_two_o;
   logic third_port_input_one_i, third_port_input_two_i;
   logic third_port_input_three_i;
   int n_errors = 0, checks_done = 0;
   assign {third_port_input_three_i, third_port_input_two_i,
      third_port_input_one_i} = tin;
   assign p3o = {third_port_output_seven_o, third_port_output_six_o,
      third_port_output_five_o, third_port_output_four_o};
   lvio_ports u_dut (.*);
   lvio_board u_b0 (.clk_i(clk_i), .oe_i(p0_pin_oe_o), .drv_i(p0_pin_o),
      .pullup_i(p0_pullup_en_o), .ext_en_i(e0), .ext_val_i(v0),
      .level_o(p0_pin_i));
   lvio_board u_b2 (.clk_i(clk_i), .oe_i(p2_pin_oe_o), .drv_i(p2_pin_o),
      .pullup_i(p2_pullup_en_o), .ext_en_i(e2), .ext_val_i(v2),
      .level_o(p2_pin_i));
   always #25 clk_i = ~clk_i;
   task automatic chk(input string s, input logic [7:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // About twenty times the expected run length
   initial begin
      #200000;
      n_errors++;
      complete_run;
   end
   initial begin
      logic [7:0] d, r, om, lv;
      logic [3:0] x;
      int c[3];
      void'($urandom(9));
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'h1;
      cyc(1);
      chk("p0 oe", p0_pin_oe_o, 8'h00);
      chk("p2 pullup", p2_pullup_en_o, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         e0 <= 8'($urandom);
         v0 <= 8'($urandom);
         {p0_mode_wr_i, p0_wr_i, port_configuration_register_wr_i} <= 3'h7;
         p0_mode_i <= i[1:0];
         p0_wdata_i <= d;
         port_configuration_register_i <= {5'h00, i[2], 2'h0};
         cyc(1);
         {p0_mode_wr_i, p0_wr_i, port_configuration_register_wr_i} <= 3'h0;
         om = {{4{i[1]}}, {4{i[0]}}};
         chk("p0 oe", p0_pin_oe_o, om & (i[2] ? 8'hFF : ~d));
         chk("p0 pullup", p0_pullup_en_o, ~om);
         chk("p0 drive", p0_pin_o, d);
         cyc(3);
         lv = (e0 & v0) | ~e0;
         chk("p0 read", p0_rdata_o, (om & d) | (~om & lv));
      end
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         r = i < 3 ? 8'hFF : 8'($urandom);
         e2 <= i < 3 ? 8'hFF : 8'($urandom);
         v2 <= i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($urandom);
         {p2_dir_wr_i, p2_wr_i} <= 2'h3;
         p2_dir_i <= r;
         p2_od_i <= i[0];
         p2_wdata_i <= d;
         cyc(1);
         {p2_dir_wr_i, p2_wr_i} <= 2'h0;
         chk("p2 oe", p2_pin_oe_o, ~r & (i[0] ? ~d : 8'hFF));
         chk("p2 pullup", p2_pullup_en_o, r);
         chk("p2 drive", p2_pin_o, d);
         cyc(3);
         lv = (e2 & v2) | ~e2;
         chk("p2 read", p2_rdata_o, (~r & d) | (r & lv));
         if (r == 8'hFF) begin
            chk("wake or", p2_wake_or_o, |lv);
            chk("wake and", p2_wake_and_o, &lv);
         end
      end
      p2_dir_wr_i <= 1'h1;
      p2_dir_i <= 8'hFF;
      e2 <= 8'hFF;
      cyc(1);
      p2_dir_wr_i <= 1'h0;
      for (int i = 0; i < 4; i++) begin
         edge_src_sel_i <= i[1];
         tin <= {2'h0, i[0]};
         v2 <= {7'h00, ~i[0]};
         cyc(4);
         chk("edge in", timer_edge_in_o, i[1] ^ i[0]);
      end
      tin <= 3'h0;
      cyc(5);
      for (int md = 0; md < 4; md++) begin
         irq_cfg_wr_i <= 1'h1;
         irq_cfg_i <= {md[1:0], 6'h00};
         cyc(1);
         irq_cfg_wr_i <= 1'h0;
         for (int lvl = 1; lvl >= 0; lvl--) begin
            tin <= {3{lvl[0]}};
            c = '{0, 0, 0};
            repeat (6) begin
               cyc(1);
               c[0] += int'(irq_req_two_o === 1'h1);
               c[1] += int'(irq_req_zero_o === 1'h1);
               c[2] += int'(interrupt_request_one_o === 1'h1);
            end
            r = 8'(lvl ? md != 0 : md != 1);
            chk("irq two", 8'(c[0]), r);
            chk("irq zero", 8'(c[1]), r);
            chk("irq one", 8'(c[2]), 8'(lvl == 0));
         end
      end
      p3_mode_wr_i <= 1'h1;
      p3_mode_i <= 8'h02;
      tin <= 3'h4;
      cyc(1);
      p3_mode_wr_i <= 1'h0;
      chk("cmp power", cmp_power_en_o, 1'h1);
      cyc(5);
      tin <= 3'h0;
      c[2] = 0;
      repeat (6) begin
         cyc(1);
         c[2] += int'(interrupt_request_one_o === 1'h1);
      end
      chk("irq one analog", 8'(c[2]), 8'h00);
      stop_mode_i <= 1'h1;
      cyc(1);
      chk("cmp power", cmp_power_en_o, 1'h0);
      chk("recovery", stop_recovery_src_o, 3'h0);
      p3_mode_wr_i <= 1'h1;
      p3_mode_i <= 8'h00;
      tin <= 3'h7;
      cyc(1);
      p3_mode_wr_i <= 1'h0;
      cyc(4);
      chk("recovery", stop_recovery_src_o, 3'h7);
      chk("p3 read", p3_rdata_o, 4'hE);
      p3_wr_i <= 1'h1;
      p3_wdata_i <= 4'hF;
      for (int i = 0; i < 8; i++) begin
         {timer_common_control_wr_i, wide_timer_control_wr_i} <= 2'h3;
         timer_common_control_i <= {2'h0, i[1:0], 4'h0};
         wide_timer_control_i <= {7'h00, i[0]};
         {narrow_counter_timer_out_i, wide_counter_timer_out_i} <= {2{i[2]}};
         and_or_logic_out_i <= ~i[2];
         cyc(1);
         {p3_wr_i, timer_common_control_wr_i, wide_timer_control_wr_i} <= 3'h0;
         cyc(3);
         x = {1'h1, i[1] ? ~i[2] : 1'h1, i[0] ? {2{i[2]}} : 2'h3};
         chk("p3 outputs", p3o, x);
      end
      complete_run;
   end
endmodule
